// ==== src/pdc_device.sv ====
// Device end: receives configuration words and decodes the dividers.
// Assumes link pins are synchronous to core_clk and change slowly
// enough that each serial clock level lasts at least one core cycle.
// Behaviour
// R1 - Host keeps large-prescaler main count at most 2045
// R2 - Second order low counts only in listed bands
// R3 - Third order low counts only in listed bands
// R4 - Fourth order low counts only in listed bands
// R5 - Main count splits coarse, middle, swallow fields
// R6 - Denominator low bits join externally held upper bits
// R7 - Reference divider takes values 1 through 63
// R8 - Select bit picks small or large prescaler
// R9 - Main power-down bit stops loop, pump floats
// R10 - Low chip enable forces main loop down
// R11 - Auto power-up overrides bit, else bit decides
// R12 - Aux field splits coarse and swallow counts
// R13 - Host avoids illegal small aux prescaler counts
// R14 - Ratio is base times coarse plus middle, swallow
// R15 - Aux power-down bit stops loop, pump floats
// R16 - Count write with auto power-up clears aux down
// R17 - Low control bits route word to register
// R18 - Main register field positions fixed
`timescale 1ns/1ps
module pdc_device (
   input wire logic core_clk,
   input wire logic nrst,
   pdc_if.dev link,
   input wire logic auto_powerup_on_write,
   input wire logic aux_small_prescaler,
   input wire logic [pdc_pkg::FDEN_HI_W-1:0] main_frac_den_upper,
   output logic [pdc_pkg::CNT_W-1:0] main_feedback_count,
   output logic [pdc_pkg::COARSE_W-1:0] main_coarse_count,
   output logic [pdc_pkg::MID_W-1:0] main_middle_count,
   output logic [pdc_pkg::SWAL_W-1:0] main_swallow_count,
   output logic [pdc_pkg::RATIO_W-1:0] main_divide_ratio,
   output logic main_prescaler_select,
   output logic [5:0] main_prescaler_base,
   output logic [pdc_pkg::REF_W-1:0] main_ref_divider,
   output logic main_ref_div_legal,
   output logic [pdc_pkg::FDEN_W+pdc_pkg::FDEN_HI_W-1:0]
      main_frac_denominator,
   output logic main_loop_powerdown,
   output logic main_loop_active,
   output logic main_cp_hiz,
   output logic aux_loop_powerdown,
   output logic aux_loop_active,
   output logic aux_cp_hiz,
   output logic [pdc_pkg::AUX_COARSE_W-1:0] aux_coarse_count,
   output logic [pdc_pkg::AUX_SWAL_W-1:0] aux_swallow_count,
   output logic [pdc_pkg::AUX_N_W-1:0] aux_divide_ratio,
   output logic word_taken
);
   import pdc_pkg::*;

   // ***********************************************
   // Layout checks
   // ***********************************************
   // The slices below only hold while the package layout stays consistent
   generate
      if (COARSE_W + MID_W + SWAL_W != CNT_W) begin : g_cnt_chk
         $error("Count subfields must fill the count field");
      end
      if (AUX_COARSE_W + AUX_SWAL_W != AUX_N_W - 1) begin : g_aux_chk
         $error("Aux subfields must leave one spare top bit");
      end
      if (FDEN_LSB + FDEN_W > REF_LSB) begin : g_fden_chk
         $error("Denominator field overlaps the reference divider");
      end
      if (REF_LSB + REF_W > MAIN_PSEL_BIT) begin : g_ref_chk
         $error("Reference divider overlaps the prescaler select");
      end
      if (CNT_LSB + CNT_W != WORD_W) begin : g_word_chk
         $error("Count field must end at the top of the word");
      end
   endgenerate

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic prev_clk;
      logic prev_le;
      logic [WORD_W-1:0] shreg;
      logic [CNT_W-1:0] cnt;
      logic cnt_written;
      logic pd;
      logic psel;
      logic [REF_W-1:0] refdiv;
      logic [FDEN_W-1:0] fden_low;
      logic [FDEN_HI_W-1:0] fden_high;
      logic aux_pd;
      logic [AUX_N_W-1:0] aux_n;
      logic [RATIO_W-1:0] ratio;
      logic [AUX_N_W-1:0] aux_ratio;
      logic main_act;
      logic aux_act;
      logic taken;
   } pdc_dev_s;

   pdc_dev_s r;
   pdc_dev_s next_r;
   logic clk_rise;
   logic le_rise;
   logic [5:0] base;
   logic [RATIO_W-1:0] prod;
   logic [AUX_N_W-1:0] aux_prod;
   logic [AUX_COARSE_W-1:0] aux_c;

   // ***********************************************
   // Receive, route and decode
   // ***********************************************
   // Edges found against the previous sample; pins are already synchronous
   always_comb begin
      next_r = r;
      next_r.taken = 1'b0;
      next_r.prev_clk = link.ser_clk;
      next_r.prev_le = link.ser_le;
      // Upper denominator bits registered so the output comes from flops
      next_r.fden_high = main_frac_den_upper; // [R6]
      clk_rise = link.ser_clk && !r.prev_clk;
      le_rise = link.ser_le && !r.prev_le;
      if (clk_rise) begin
         next_r.shreg = {r.shreg[WORD_W-2:0], link.ser_data};
      end
      if (le_rise) begin
         // Counter word is picked by its single select bit
         if (r.shreg[CNT_SEL_BIT] == CNT_SEL_VAL) begin
            next_r.cnt = r.shreg[CNT_LSB +: CNT_W];
            next_r.taken = 1'b1;
            if (auto_powerup_on_write) begin
               next_r.cnt_written = 1'b1; // [R11]
               next_r.aux_pd = 1'b0; // [R16]
            end
         end else if (r.shreg[CTRL_W-1:0] == CTRL_MAIN) begin // [R17]
            next_r.pd = r.shreg[MAIN_PD_BIT]; // [R18] [R9]
            next_r.psel = r.shreg[MAIN_PSEL_BIT]; // [R18]
            next_r.refdiv = r.shreg[REF_LSB +: REF_W]; // [R18]
            next_r.fden_low = r.shreg[FDEN_LSB +: FDEN_W]; // [R18] [R6]
            next_r.taken = 1'b1;
         end else if (r.shreg[CTRL_W-1:0] == CTRL_AUX) begin // [R17]
            next_r.aux_pd = r.shreg[AUX_PD_BIT]; // [R15]
            next_r.aux_n = r.shreg[AUX_N_LSB +: AUX_N_W];
            next_r.taken = 1'b1;
         end
      end
      // Prescaler base picked by the select bit
      base = next_r.psel ? PRESC_LARGE : PRESC_SMALL; // [R8]
      // Ratio of the three counts; widest case 32*63+4*7+3 fits 12 bits
      prod = RATIO_W'(base) *
         RATIO_W'(next_r.cnt[CNT_W-1 -: COARSE_W]); // [R5] [R14]
      next_r.ratio = prod +
         RATIO_W'(MID_WEIGHT) * RATIO_W'(next_r.cnt[SWAL_W +: MID_W]) +
         RATIO_W'(next_r.cnt[SWAL_W-1:0]); // [R14]
      // Small aux prescaler: top field bit unused, 8 times coarse plus swallow
      aux_c = next_r.aux_n[AUX_SWAL_W +: AUX_COARSE_W]; // [R12]
      aux_prod = {1'b0, aux_c, AUX_PRESC};
      if (aux_small_prescaler) begin
         next_r.aux_ratio = aux_prod +
            AUX_N_W'(next_r.aux_n[AUX_SWAL_W-1:0]); // [R12]
      end else begin
         next_r.aux_ratio = next_r.aux_n;
      end
      // Chip enable first, then auto power-up, then the bit
      next_r.main_act = link.chip_en &&
         ((auto_powerup_on_write && next_r.cnt_written) ||
         !next_r.pd); // [R10] [R11] [R9]
      next_r.aux_act = link.chip_en && !next_r.aux_pd; // [R15] [R16]
      if (!auto_powerup_on_write) begin
         next_r.cnt_written = 1'b0;
      end
   end

   // State register; both loops start powered down
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.pd <= MAIN_PD_RST;
         r.aux_pd <= AUX_PD_RST;
      end else begin
         r <= next_r;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   // Main count and its split fields
   assign main_feedback_count = r.cnt;
   assign main_coarse_count = r.cnt[CNT_W-1 -: COARSE_W]; // [R5]
   assign main_middle_count = r.cnt[SWAL_W +: MID_W]; // [R5]
   assign main_swallow_count = r.cnt[SWAL_W-1:0]; // [R5]
   assign main_divide_ratio = r.ratio;
   assign main_prescaler_select = r.psel;
   assign main_prescaler_base = r.psel ? PRESC_LARGE : PRESC_SMALL; // [R8]
   assign main_ref_divider = r.refdiv;
   // Zero has no meaning as a divide value
   assign main_ref_div_legal = (r.refdiv >= REF_MIN); // [R7]
   assign main_frac_denominator = {r.fden_high, r.fden_low}; // [R6]
   // Power state; a pump floats whenever its loop is down
   assign main_loop_powerdown = r.pd;
   assign main_loop_active = r.main_act;
   assign main_cp_hiz = !r.main_act; // [R9]
   assign aux_loop_powerdown = r.aux_pd;
   assign aux_loop_active = r.aux_act;
   assign aux_cp_hiz = !r.aux_act; // [R15]
   // Aux split count, meaningful with the small prescaler only
   assign aux_coarse_count = r.aux_n[AUX_SWAL_W +: AUX_COARSE_W]; // [R12]
   assign aux_swallow_count = r.aux_n[AUX_SWAL_W-1:0]; // [R12]
   assign aux_divide_ratio = r.aux_ratio;
   assign word_taken = r.taken;
endmodule

// ==== src/pdc_host.sv ====
// Host end: checks and shifts 24-bit configuration words out serially.
// Assumes the user holds word_in stable while word_valid is high.
`timescale 1ns/1ps
module pdc_host #(
   parameter int HALF_CYC = pdc_pkg::SER_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   pdc_if.host link,
   input wire logic [pdc_pkg::WORD_W-1:0] word_in,
   input wire logic word_valid,
   output logic word_ready,
   input wire logic [1:0] mod_order,
   input wire logic aux_small_prescaler,
   input wire logic ce_in,
   output logic word_done,
   output logic word_reject
);
   import pdc_pkg::*;

   // ***********************************************
   // Checks and state
   // ***********************************************
   generate
      if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
         $error("HALF_CYC must lie in 1..255");
      end
   endgenerate

   // Main count check; prescaler state tracks the last main word sent
   function automatic logic main_ok(input int v, input logic [1:0] ord);
      logic ok;
      ok = 1'b0;
      if (v < MAIN_BAND_END) begin
         for (int i = 0; i < 5; i++) begin
            if (ord == ORD2 && v >= B2_LO[i] && v <= B2_HI[i]) ok = 1'b1; // [R2]
         end
         for (int i = 0; i < 4; i++) begin
            if (ord == ORD3 && v >= B3_LO[i] && v <= B3_HI[i]) ok = 1'b1; // [R3]
            if (ord == ORD4 && v >= B4_LO[i] && v <= B4_HI[i]) ok = 1'b1; // [R4]
         end
      end else if (v <= MAIN_FREE_MAX) begin
         ok = 1'b1;
      end else if (v <= MAIN_ORD23_MAX) begin
         ok = (ord == ORD2) || (ord == ORD3); // [R1]
      end else if (v <= MAIN_MAX) begin
         ok = (ord == ORD2); // [R1]
      end
      return ok;
   endfunction

   function automatic logic aux_ok(input int v);
      logic ok;
      ok = 1'b0;
      if (v >= AUX_FREE_MIN) begin
         ok = (v <= AUX_MAX); // [R13]
      end else if (v >= AUX_MIN) begin
         for (int i = 0; i < 4; i++) begin
            if (v >= BA_LO[i] && v <= BA_HI[i]) ok = 1'b1; // [R13]
         end
      end
      return ok;
   endfunction

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_LATCH = 2'b10
   } pdc_hst_e;

   typedef struct packed {
      pdc_hst_e state;
      logic [WORD_W-1:0] shreg;
      logic [4:0] bitcnt;
      logic [7:0] divcnt;
      logic sclk;
      logic sdata;
      logic le;
      logic ce;
      logic psel_sent;
      logic done;
      logic reject;
   } pdc_hst_s;

   pdc_hst_s r;
   pdc_hst_s next_r;
   logic legal;
   logic is_cnt;
   logic is_main;
   logic is_aux;

   // ***********************************************
   // Next state
   // ***********************************************
   // Refuse feedback counts the device cannot divide by, rather than send them
   always_comb begin
      is_cnt = (word_in[CNT_SEL_BIT] == CNT_SEL_VAL);
      is_main = (word_in[CTRL_W-1:0] == CTRL_MAIN);
      is_aux = (word_in[CTRL_W-1:0] == CTRL_AUX);
      legal = 1'b1;
      if (is_cnt && r.psel_sent) begin
         legal = main_ok(int'(word_in[CNT_LSB +: CNT_W]), mod_order);
      end
      if (is_aux && aux_small_prescaler) begin
         legal = aux_ok(int'(word_in[AUX_N_LSB +: AUX_N_W]));
      end
      next_r = r;
      next_r.done = 1'b0;
      next_r.reject = 1'b0;
      next_r.ce = ce_in;
      unique case (r.state)
         ST_IDLE: begin
            next_r.sclk = 1'b0;
            next_r.le = 1'b0;
            if (word_valid && !legal) begin
               next_r.reject = 1'b1;
            end else if (word_valid) begin
               next_r.state = ST_SHIFT;
               next_r.shreg = word_in;
               next_r.sdata = word_in[WORD_W-1];
               next_r.bitcnt = 5'(WORD_W - 1);
               next_r.divcnt = 8'(HALF_CYC - 1);
               if (is_main) next_r.psel_sent = word_in[MAIN_PSEL_BIT];
            end
         end
         ST_SHIFT: begin
            if (r.divcnt != 8'h00) begin
               next_r.divcnt = r.divcnt - 8'h01;
            end else begin
               next_r.divcnt = 8'(HALF_CYC - 1);
               next_r.sclk = !r.sclk;
               // Data changes on the falling edge, MSB first
               if (r.sclk) begin
                  if (r.bitcnt == 5'h00) begin
                     next_r.state = ST_LATCH;
                     next_r.le = 1'b1;
                  end else begin
                     next_r.bitcnt = r.bitcnt - 5'h01;
                     next_r.shreg = {r.shreg[WORD_W-2:0], 1'b0};
                     next_r.sdata = r.shreg[WORD_W-2];
                  end
               end
            end
         end
         ST_LATCH: begin
            if (r.divcnt != 8'h00) begin
               next_r.divcnt = r.divcnt - 8'h01;
            end else begin
               next_r.state = ST_IDLE;
               next_r.le = 1'b0;
               next_r.done = 1'b1;
            end
         end
         default: next_r.state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign word_ready = (r.state == ST_IDLE);
   assign word_done = r.done;
   assign word_reject = r.reject;
   assign link.ser_clk = r.sclk;
   assign link.ser_data = r.sdata;
   assign link.ser_le = r.le;
   assign link.chip_en = r.ce;
endmodule

// ==== src/pdc_if.sv ====
// Three-wire serial configuration link plus chip enable.
// Assumes the testbench joins the host and device ends through it.
`timescale 1ns/1ps
interface pdc_if;
   logic ser_clk;
   logic ser_data;
   logic ser_le;
   logic chip_en;
   modport host (output ser_clk, output ser_data, output ser_le,
      output chip_en);
   modport dev (input ser_clk, input ser_data, input ser_le,
      input chip_en);
endinterface

// ==== src/pdc_pkg.sv ====
// Shared constants for the synthesizer divider configuration link.
// Assumes both ends are clocked by core_clk at 125 MHz.
package pdc_pkg;
   // ***********************************************
   // Word layout
   // ***********************************************
   localparam int WORD_W = 24;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_MAIN = 4'h3;
   localparam logic [3:0] CTRL_AUX = 4'h5;
   localparam int CNT_SEL_BIT = 0;
   localparam logic CNT_SEL_VAL = 1'h0;
   localparam int MAIN_PD_BIT = 23;
   localparam int MAIN_PSEL_BIT = 22;
   localparam int REF_LSB = 16;
   localparam int REF_W = 6;
   localparam int FDEN_LSB = 4;
   localparam int FDEN_W = 12;
   localparam int FDEN_HI_W = 10;
   localparam int CNT_LSB = 13;
   localparam int CNT_W = 11;
   localparam int COARSE_W = 6;
   localparam int MID_W = 3;
   localparam int SWAL_W = 2;
   localparam int RATIO_W = 12;
   localparam int AUX_PD_BIT = 23;
   localparam int AUX_N_LSB = 4;
   localparam int AUX_N_W = 19;
   localparam int AUX_COARSE_W = 15;
   localparam int AUX_SWAL_W = 3;
   // ***********************************************
   // Divider constants and reset values
   // ***********************************************
   localparam logic [5:0] PRESC_SMALL = 6'h10;
   localparam logic [5:0] PRESC_LARGE = 6'h20;
   localparam logic [2:0] MID_WEIGHT = 3'h4;
   localparam logic [2:0] AUX_PRESC = 3'h0;
   localparam logic [5:0] REF_MIN = 6'h01;
   localparam logic MAIN_PD_RST = 1'h1;
   localparam logic AUX_PD_RST = 1'h1;
   // ***********************************************
   // Legal feedback counts
   // ***********************************************
   localparam logic [1:0] ORD2 = 2'h0;
   localparam logic [1:0] ORD3 = 2'h1;
   localparam logic [1:0] ORD4 = 2'h2;
   localparam int MAIN_BAND_END = 227;
   localparam int MAIN_FREE_MAX = 2039;
   localparam int MAIN_ORD23_MAX = 2043;
   localparam int MAIN_MAX = 2045;
   localparam int B2_LO [5] = '{97, 129, 161, 193, 225};
   localparam int B2_HI [5] = '{109, 145, 181, 217, 226};
   localparam int B3_LO [4] = '{99, 131, 163, 195};
   localparam int B3_HI [4] = '{107, 143, 179, 215};
   localparam int B4_LO [4] = '{103, 135, 167, 199};
   localparam int B4_HI [4] = '{103, 139, 175, 211};
   localparam int AUX_MIN = 24;
   localparam int AUX_FREE_MIN = 56;
   localparam int AUX_MAX = 262143;
   localparam int BA_LO [4] = '{24, 32, 40, 48};
   localparam int BA_HI [4] = '{27, 36, 45, 54};
   // ***********************************************
   // Serial timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int SER_HALF_NS = 40;
   localparam int SER_HALF_CYC =
      (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== verification/pdc_link_chk.sv ====
// Checker for the serial link between the host and device ends.
// Assumes it sits beside the link interface, fed its signals by name.
`timescale 1ns/1ps
module pdc_link_chk #(
   parameter int HALF_CYC = 5
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_le,
   input wire logic chip_en
);
   // ***********************************************
   // Word capture helpers
   // ***********************************************
   logic clk_q, le_q, psel_q, le_rise;
   logic [23:0] sh;
   int bits, crun, lrun;
   assign le_rise = ser_le && !le_q;
   // Rebuild each word so its legality can be judged at the latch
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clk_q <= 1'h0;
         le_q <= 1'h0;
         psel_q <= 1'h0;
         sh <= 24'h000000;
         bits <= 0;
         crun <= 0;
         lrun <= 0;
      end else begin
         clk_q <= ser_clk;
         le_q <= ser_le;
         if (ser_clk && !clk_q) begin
            sh <= {sh[22:0], ser_data};
         end
         bits <= le_rise ? 0 : bits + int'(ser_clk && !clk_q);
         crun <= (ser_clk != clk_q) ? 1 : crun + 1;
         lrun <= (ser_le != le_q) ? 1 : lrun + 1;
         // Prescaler choice follows the last main word latched
         if (le_rise && sh[3:0] == 4'h3) begin
            psel_q <= sh[22];
         end
      end
   end
   // ***********************************************
   // Link properties
   // ***********************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_le_clk_low;
      le_rise |-> !ser_clk;
   endproperty
   a_le_clk_low: assert property (p_le_clk_low)
      else $error("latch rose with serial clock high");
   property p_no_clk_in_latch;
      (le_q && ser_le) |-> !ser_clk;
   endproperty
   a_no_clk_in_latch: assert property (p_no_clk_in_latch)
      else $error("serial clock high during latch");
   property p_data_stable;
      (ser_clk && clk_q) |-> $stable(ser_data);
   endproperty
   a_data_stable: assert property (p_data_stable)
      else $error("serial data moved while clock high");
   property p_clk_hold;
      (ser_clk != clk_q) |-> crun >= HALF_CYC;
   endproperty
   a_clk_hold: assert property (p_clk_hold)
      else $error("serial clock level too short");
   property p_le_width;
      (le_q && !ser_le) |-> lrun == HALF_CYC;
   endproperty
   a_le_width: assert property (p_le_width)
      else $error("latch pulse width wrong");
   property p_word_bits;
      le_rise |-> bits == 24;
   endproperty
   a_word_bits: assert property (p_word_bits)
      else $error("latched word not 24 bits");
   property p_count_max;
      (le_rise && !sh[0] && psel_q) |-> sh[23:13] <= 11'h7FD;
   endproperty
   a_count_max: assert property (p_count_max)
      else $error("main count above limit sent");
   property p_count_min;
      (le_rise && !sh[0] && psel_q) |-> sh[23:13] >= 11'h061;
   endproperty
   a_count_min: assert property (p_count_min)
      else $error("main count below lowest band sent");
endmodule

// ==== verification/pll_divider_config_regs_tb.sv ====
// Testbench joining host and device ends through the serial link.
// Assumes the package, interface and both end modules are compiled first.
`timescale 1ns/1ps
module pll_divider_config_regs_tb;
   import pdc_pkg::*;
   // ***********************************************
   // Signals and instances
   // ***********************************************
   localparam int HALF = 2;
   localparam int CNTS [14] = '{2046, 2045, 2045, 2043, 2043, 110, 109,
      108, 107, 103, 104, 96, 226, 231};
   localparam int ORDS [14] = '{0, 0, 1, 1, 2, 0, 0, 1, 1, 2, 2, 0, 0, 0};
   localparam logic [13:0] CREJ = 14'h0CB5;
   localparam int AUXN [8] = '{23, 28, 24, 54, 55, 56, 262144, 262143};
   localparam logic [7:0] AREJ = 8'h53;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [WORD_W-1:0] word_in = '0;
   logic word_valid = 1'b0;
   logic [1:0] mod_order = 2'h0;
   logic aux_small = 1'b0;
   logic ce_in = 1'b1;
   logic auto_pu = 1'b0;
   logic [FDEN_HI_W-1:0] den_hi = 10'h2A5;
   logic word_ready, word_done, word_reject, word_taken;
   logic [10:0] fb;
   logic [5:0] coarse, base, refd;
   logic [2:0] mid, aswal;
   logic [1:0] swal;
   logic [11:0] ratio;
   logic [21:0] fden;
   logic [14:0] acoarse;
   logic [18:0] aratio;
   logic psel, ref_ok, mpd, mact, mhiz, apd, aact, ahiz;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int taken = 0;
   pdc_if link();
   pdc_host #(.HALF_CYC(HALF)) u_pdc_host (.core_clk(core_clk),
      .nrst(nrst), .link(link), .word_in(word_in),
      .word_valid(word_valid), .word_ready(word_ready),
      .mod_order(mod_order), .aux_small_prescaler(aux_small),
      .ce_in(ce_in), .word_done(word_done), .word_reject(word_reject));
   pdc_device u_pdc_device (.core_clk(core_clk), .nrst(nrst),
      .link(link), .auto_powerup_on_write(auto_pu),
      .aux_small_prescaler(aux_small), .main_frac_den_upper(den_hi),
      .main_feedback_count(fb), .main_coarse_count(coarse),
      .main_middle_count(mid), .main_swallow_count(swal),
      .main_divide_ratio(ratio), .main_prescaler_select(psel),
      .main_prescaler_base(base), .main_ref_divider(refd),
      .main_ref_div_legal(ref_ok), .main_frac_denominator(fden),
      .main_loop_powerdown(mpd), .main_loop_active(mact),
      .main_cp_hiz(mhiz), .aux_loop_powerdown(apd),
      .aux_loop_active(aact), .aux_cp_hiz(ahiz),
      .aux_coarse_count(acoarse), .aux_swallow_count(aswal),
      .aux_divide_ratio(aratio), .word_taken(word_taken));
   pdc_link_chk #(.HALF_CYC(HALF)) u_pdc_link_chk (.core_clk(core_clk),
      .nrst(nrst), .ser_clk(link.ser_clk), .ser_data(link.ser_data),
      .ser_le(link.ser_le), .chip_en(link.chip_en));
   // ***********************************************
   // Clock, watchdog and helpers
   // ***********************************************
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   // Watchdog well above the roughly 2000 cycles the sequence needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (word_taken === 1'b1) begin
         taken <= taken + 1;
      end
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Hold the request until taken, then wait for done or reject
   task automatic send(input logic [23:0] w, input logic rej);
      int n;
      @(negedge core_clk);
      word_in = w;
      word_valid = 1'b1;
      for (n = 0; n < 50 && word_ready !== 1'b1; n++) @(negedge core_clk);
      @(negedge core_clk);
      word_valid = 1'b0;
      for (n = 0; n < 400 && word_done !== 1'b1 && word_reject !== 1'b1;
         n++) @(negedge core_clk);
      check(word_done | word_reject, 1'b1);
      check(word_reject, rej);
      repeat (2) @(negedge core_clk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ***********************************************
   // Test sequence
   // ***********************************************
   initial begin
      int t0;
      repeat (6) @(negedge core_clk);
      nrst = 1'b1;
      check({mpd, apd, mhiz, ahiz}, 4'hF);
      send({1'b0, 1'b1, 6'h3F, 12'hABC, CTRL_MAIN}, 1'b0);
      check({refd, ref_ok}, {6'h3F, 1'b1});
      check({psel, base}, {1'b1, PRESC_LARGE});
      check(fden, {den_hi, 12'hABC});
      check({mpd, mact, mhiz}, 3'h2);
      ce_in = 1'b0;
      repeat (3) @(negedge core_clk);
      check({mact, mhiz}, 2'h1);
      ce_in = 1'b1;
      // Large prescaler count bands for every modulator order
      for (int i = 0; i < 14; i++) begin
         mod_order = 2'(ORDS[i]);
         send({11'(CNTS[i]), 12'h000, 1'b0}, CREJ[i]);
         if (!CREJ[i]) check(ratio, 32'(CNTS[i]));
      end
      check({coarse, mid, swal, fb}, {6'h07, 3'h1, 2'h3, 11'h0E7});
      send({1'b1, 1'b0, 6'h00, 12'h001, CTRL_MAIN}, 1'b0);
      check({ref_ok, base}, {1'b0, PRESC_SMALL});
      check({mpd, mact, mhiz}, 3'h5);
      // Count write with auto power-up wakes both loops
      auto_pu = 1'b1;
      send({11'h0E7, 12'h000, 1'b0}, 1'b0);
      check(ratio, 12'h077);
      check({mact, mhiz, apd, aact, ahiz}, 5'h12);
      ce_in = 1'b0;
      repeat (3) @(negedge core_clk);
      check({mact, aact, ahiz}, 3'h1);
      ce_in = 1'b1;
      auto_pu = 1'b0;
      repeat (4) @(negedge core_clk);
      check({mact, mhiz}, 2'h1);
      // Aux counts without then with the small prescaler check
      send({1'b0, 19'h00017, CTRL_AUX}, 1'b0);
      check(aratio, 19'h00017);
      aux_small = 1'b1;
      for (int i = 0; i < 8; i++) begin
         send({1'b0, 19'(AUXN[i]), CTRL_AUX}, AREJ[i]);
         if (!AREJ[i]) check(aratio, 32'(AUXN[i]));
      end
      check({acoarse, aswal}, {15'h7FFF, 3'h7});
      check({apd, aact, ahiz}, 3'h2);
      send({1'b1, 19'h00038, CTRL_AUX}, 1'b0);
      check({apd, aact, ahiz}, 3'h5);
      // Unrouted control code leaves registers alone
      t0 = taken;
      send({20'hFFFFF, 4'h7}, 1'b0);
      check(taken, t0);
      check(refd, 6'h00);
      stop_test();
   end
endmodule
